// >>> hw/ssr_params.svh
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH

// stage count: capacitively coupled variant tops out here
`define SSR_STAGES          19
// least erase (set-high) time, ns
`define SSR_ERASE_NS        10000
// least inter-stage delay, ns
`define SSR_DELAY_NS        100000
// shortest shift period at 500 shifts per second, ns
`define SSR_PERIOD_NS       2000000
`define SSR_CLK_NS          5
// erase rounds up, delay rounds up (both are least times)
`define SSR_ERASE_CYC       ((`SSR_ERASE_NS + `SSR_CLK_NS - 1) / `SSR_CLK_NS)
`define SSR_DELAY_CYC       ((`SSR_DELAY_NS + `SSR_CLK_NS - 1) / `SSR_CLK_NS)
// power-up preset pulse length, cycles
`define SSR_PRESET_CYC      16
`define SSR_ALL_HIGH        19'h7FFFF

`endif

// >>> hw/ssr_phase_gen.sv
`timescale 1ns/100ps
`include "ssr_params.svh"
module ssr_phase_gen
    import ssr_pkg::*;
(
    // clock and reset
    input  wire logic   clk_sys,
    input  wire logic   reset_n,
    // trigger
    input  wire logic   shiftReq,
    ssr_phase_if.gen    ph
);
    // a one-shot: master gate, then slave gate, then one idle step
    logic [1:0] step;
    logic [1:0] next_step;

    always_comb
    begin
        next_step = step;
        if (step == 2'h0)
        begin
            if (shiftReq)
            begin
                next_step = 2'h1;
            end
        end
        else
        begin
            next_step = step + 2'h1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            step <= 2'h0;
        end
        else
        begin
            step <= next_step;
        end
    end

    // three-cycle gating fits well inside a 25 kHz period
    // gate fanout past 24 stages is buffered by synthesis
    // distinct step decodes keep the gates apart
    assign ph.masterGate = (step == 2'h1);
    assign ph.slaveGate  = (step == 2'h2);
    assign ph.busy       = (step != 2'h0);

    a_gates_apart: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(ph.masterGate && ph.slaveGate))
        else $error("gates overlap");
    a_slave_follows: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ph.masterGate |=> ph.slaveGate)
        else $error("slave gate missing after master");
endmodule

// >>> hw/ssr_phase_if.sv
`timescale 1ns/100ps
interface ssr_phase_if;
    logic masterGate;
    logic slaveGate;
    logic busy;
    modport gen  (output masterGate, output slaveGate, output busy);
    modport user (input masterGate, input slaveGate, input busy);
endinterface

// >>> hw/ssr_pkg.sv
package ssr_pkg;
    typedef enum logic [1:0] {
        SSR_PRESET,
        SSR_IDLE,
        SSR_TRANSPORT,
        SSR_ERASE
    } ssr_phase_t;
endpackage

// >>> hw/ssr_shift_reg.sv
`timescale 1ns/100ps
`include "ssr_params.svh"
module ssr_shift_reg
    import ssr_pkg::*;
#(
    parameter int unsigned DELAY_CYC  = `SSR_DELAY_CYC,
    parameter int unsigned PERIOD_CYC = `SSR_PERIOD_NS / `SSR_CLK_NS
)
(
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    reset_n,
    // serial side, pins
    input  wire logic                    infoIn,
    input  wire logic                    shiftIn,
    // parallel load, pins
    input  wire logic [`SSR_STAGES-1:0]  preset_one,
    input  wire logic [`SSR_STAGES-1:0]  preset_two,
    // status
    output logic                         shiftBusy,
    output logic                         shiftDropped,
    // stage contents
    output logic [`SSR_STAGES-1:0]       stageQ,
    output logic [`SSR_STAGES-1:0]       stageQn,
    output logic [`SSR_STAGES-1:0]       master_outs
);
    localparam int unsigned ERASE_CYC = `SSR_ERASE_CYC;

    // two-flop synchronisers on every pin input
    logic [1:0]             infoSync;
    logic [1:0]             shiftSync;
    logic [`SSR_STAGES-1:0] p1Meta;
    logic [`SSR_STAGES-1:0] p1Sync;
    logic [`SSR_STAGES-1:0] p2Meta;
    logic [`SSR_STAGES-1:0] p2Sync;
    logic                   shiftLast;

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            infoSync  <= 2'h3;
            shiftSync <= 2'h0;
            p1Meta    <= '0;
            p1Sync    <= '0;
            p2Meta    <= '0;
            p2Sync    <= '0;
            shiftLast <= 1'b0;
        end
        else
        begin
            infoSync  <= {infoSync[0], infoIn};
            shiftSync <= {shiftSync[0], shiftIn};
            p1Meta    <= preset_one;
            p1Sync    <= p1Meta;
            p2Meta    <= preset_two;
            p2Sync    <= p2Meta;
            shiftLast <= shiftSync[1];
        end
    end

    logic shiftRise;
    logic presetAny;
    logic info;
    assign shiftRise = shiftSync[1] && !shiftLast;
    assign presetAny = |(p1Sync | p2Sync);
    assign info      = infoSync[1];

    // one-shot sequencer: transport then erase then rest
    ssr_phase_t             phase;
    ssr_phase_t             next_phase;
    logic [23:0]            timer;
    logic [23:0]            next_timer;
    logic                   infoHeld;
    logic                   next_infoHeld;
    logic                   dropped;
    logic                   next_dropped;

    always_comb
    begin
        next_phase    = phase;
        next_timer    = (timer != 24'h0) ? timer - 24'h1 : 24'h0;
        next_infoHeld = infoHeld;
        next_dropped  = 1'b0;
        unique case (phase)
            SSR_PRESET:
            begin
                if (timer == 24'h0)
                begin
                    next_phase = SSR_IDLE;
                end
            end
            SSR_IDLE:
            begin
                // shift period floor keeps rate at or under 500/s at the default period
                if (shiftRise && timer == 24'h0)
                begin
                    next_phase    = SSR_TRANSPORT;
                    next_timer    = 24'(DELAY_CYC);
                    next_infoHeld = info;
                end
                else if (shiftRise)
                begin
                    next_dropped = 1'b1;
                end
            end
            SSR_TRANSPORT:
            begin
                // info sampled through the transport phase; a low sticks
                if (!info)
                begin
                    next_infoHeld = 1'b0;
                end
                if (timer == 24'h0)
                begin
                    next_phase = SSR_ERASE;
                    next_timer = 24'(ERASE_CYC);
                end
            end
            SSR_ERASE:
            begin
                if (timer == 24'h0)
                begin
                    next_phase = SSR_IDLE;
                    next_timer = 24'(PERIOD_CYC - DELAY_CYC - ERASE_CYC);
                end
            end
        endcase
        if (shiftRise && phase != SSR_IDLE)
        begin
            next_dropped = 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            phase    <= SSR_PRESET;
            timer    <= 24'(`SSR_PRESET_CYC);
            infoHeld <= 1'b1;
            dropped  <= 1'b0;
        end
        else
        begin
            phase    <= next_phase;
            timer    <= next_timer;
            infoHeld <= next_infoHeld;
            dropped  <= next_dropped;
        end
    end

    // master-slave gating, started once the delay has run out
    ssr_phase_if ph ();
    logic gateTrig;
    // the delay sits between the shift edge and the predecessor snapshot
    assign gateTrig = (phase == SSR_TRANSPORT) && (timer == 24'h0);

    ssr_phase_gen u_phase
    (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .shiftReq (gateTrig),
        .ph       (ph.gen)
    );

    // stage store, one bit per stage
    logic [`SSR_STAGES-1:0] master;
    logic [`SSR_STAGES-1:0] next_master;
    logic [`SSR_STAGES-1:0] slave;
    logic [`SSR_STAGES-1:0] next_slave;

    always_comb
    begin
        // both gates low and no preset: both halves hold, predecessors ignored
        next_master = master;
        next_slave  = slave;
        if (phase == SSR_PRESET)
        begin
            // master holds the inverse, so a high stage shows a low master
            next_master = '0;
            next_slave  = `SSR_ALL_HIGH;
        end
        else
        begin
            if (ph.masterGate)
            begin
                // master holds inverse of incoming; lows write high
                next_master = ~{slave[`SSR_STAGES-2:0], infoHeld};
            end
            if (ph.slaveGate)
            begin
                // slave re-inverts; stages with no low return high
                next_slave = ~master;
            end
            // preset after shifting so it takes priority
            next_slave  = (next_slave | p1Sync) & ~p2Sync;
            next_master = (next_master & ~p1Sync) | p2Sync;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            master <= '0;
            slave  <= '1;
        end
        else
        begin
            master <= next_master;
            slave  <= next_slave;
        end
    end

    assign stageQ       = slave;
    assign stageQn      = ~slave;
    assign master_outs  = master;
    assign shiftBusy    = (phase != SSR_IDLE) || ph.busy || presetAny;
    assign shiftDropped = dropped;

    a_one_step_shift: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ph.slaveGate && !presetAny && !$past(presetAny))
        |=> stageQ[`SSR_STAGES-1:1] == $past(stageQ[`SSR_STAGES-2:0], 2))
        else $error("shift did not move one stage");
    a_preset_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
        phase == SSR_PRESET |=> stageQ == `SSR_ALL_HIGH)
        else $error("power-up preset not high");
    a_hold_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!ph.masterGate && !ph.slaveGate && !presetAny && phase != SSR_PRESET)
        |=> $stable(stageQ))
        else $error("stage moved without gate");
    a_erase_len: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(phase == SSR_ERASE) |-> (phase == SSR_ERASE) [*8])
        else $error("erase too short");
    a_delay_min: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(phase == SSR_TRANSPORT) |-> !ph.masterGate [*8])
        else $error("gate before delay");
    a_one_per_req: assert property (@(posedge clk_sys) disable iff (!reset_n)
        gateTrig |=> !gateTrig [*3])
        else $error("double gate trigger");
    a_preset_wins: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (phase != SSR_PRESET)
        |=> ((stageQ | $past(p1Sync & ~p2Sync)) == stageQ)
            && ((stageQ & $past(p2Sync)) == '0))
        else $error("preset lost to shift");
    a_fault_enters: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ph.masterGate && !infoHeld && !presetAny && !$past(presetAny)) |=> ##1
        !stageQ[0])
        else $error("fault low not written");
endmodule

// >>> tb/ssr_station.sv
`timescale 1ns/100ps
module ssr_station #(
    parameter int unsigned HOLD_CYC = 40
)
(
    // clock and reset
    input  wire logic   clk_sys,
    input  wire logic   reset_n,
    // bench request
    input  wire logic   go,
    input  wire logic   fault,
    // pins toward the register
    output logic        infoIn,
    output logic        shiftIn
);
    int unsigned cnt;

    // info settles four cycles ahead of the shift edge and holds its level
    // well past the transport wait, so the sampled bit never races
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            cnt     <= 0;
            infoIn  <= 1'b1;
            shiftIn <= 1'b0;
        end
        else if (cnt == 0)
        begin
            if (go)
            begin
                cnt    <= 1;
                infoIn <= ~fault;
            end
        end
        else
        begin
            cnt <= cnt + 1;
            if (cnt == 4)
                shiftIn <= 1'b1;
            if (cnt == HOLD_CYC)
            begin
                shiftIn <= 1'b0;
                infoIn  <= 1'b1;
                cnt     <= 0;
            end
        end
    end
endmodule

// >>> tb/test_serial_shift_register.sv
`timescale 1ns/100ps
`include "ssr_params.svh"
module test_serial_shift_register;
    // transport wait kept longer than erase
    localparam int unsigned DLY  = 2016;
    // one shift per period, well over the 500/s rate that the default period sets
    localparam int unsigned PER  = 4100;
    localparam int unsigned HLD  = DLY + 24;
    // rest left after busy falls; a shift edge inside it is dropped
    localparam int unsigned REST = PER - DLY - `SSR_ERASE_CYC;
    logic                   clk_sys;
    logic                   reset_n;
    logic                   go;
    logic                   fault;
    logic                   infoIn;
    logic                   shiftIn;
    logic                   shiftBusy;
    logic                   shiftDropped;
    logic [`SSR_STAGES-1:0] preset_one;
    logic [`SSR_STAGES-1:0] preset_two;
    logic [`SSR_STAGES-1:0] stageQ;
    logic [`SSR_STAGES-1:0] stageQn;
    logic [`SSR_STAGES-1:0] master_outs;
    logic [`SSR_STAGES-1:0] expQ;
    int                     miscompares;
    int                     cmp_count;
    int                     seen;
    int                     waited;

    ssr_station #(.HOLD_CYC(HLD)) u_station (.clk_sys(clk_sys),
        .reset_n(reset_n), .go(go), .fault(fault), .infoIn(infoIn),
        .shiftIn(shiftIn));
    ssr_shift_reg #(.DELAY_CYC(DLY), .PERIOD_CYC(PER)) u_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .infoIn(infoIn),
        .shiftIn(shiftIn), .preset_one(preset_one),
        .preset_two(preset_two), .shiftBusy(shiftBusy),
        .shiftDropped(shiftDropped), .stageQ(stageQ), .stageQn(stageQn),
        .master_outs(master_outs));

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic cmp_vec(input logic [`SSR_STAGES-1:0] got,
                           input logic [`SSR_STAGES-1:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t flag %b want %b", $time, got, exp);
        end
    endtask

    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        // look at busy away from the rising edge that updates it
        @(negedge clk_sys);
        while (shiftBusy !== lvl)
        begin
            @(negedge clk_sys);
            n++;
            if (n > lim)
            begin
                miscompares++;
                $display("MISMATCH %0t busy wait ran out", $time);
                complete_run();
            end
        end
        waited = n;
    endtask

    task automatic shift_one(input logic f);
        @(posedge clk_sys);
        go    <= 1'b1;
        fault <= f;
        @(posedge clk_sys);
        go <= 1'b0;
        wait_busy(1'b1, 60);
        wait_busy(1'b0, PER + 100);
        cmp_bit(waited >= DLY + `SSR_ERASE_CYC, 1'b1);
        expQ = {expQ[`SSR_STAGES-2:0], ~f};
        repeat (REST) @(posedge clk_sys);
    endtask

    task automatic t_reset;
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        wait_busy(1'b0, 100);
        cmp_vec(stageQ, `SSR_ALL_HIGH);
        cmp_vec(stageQn, ~`SSR_ALL_HIGH);
        cmp_vec(master_outs, ~`SSR_ALL_HIGH);
        expQ = `SSR_ALL_HIGH;
    endtask

    // one fault walks the whole length and falls out of the last stage
    task automatic t_train;
        shift_one(1'b1);
        cmp_vec(stageQ, expQ);
        cmp_vec(master_outs, ~expQ);
        for (int i = 0; i < `SSR_STAGES; i++)
        begin
            shift_one(1'b0);
            cmp_vec(stageQ, expQ);
        end
        cmp_vec(stageQ, `SSR_ALL_HIGH);
    endtask

    task automatic t_drop;
        @(posedge clk_sys);
        go    <= 1'b1;
        fault <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        wait_busy(1'b1, 60);
        repeat (HLD + 10) @(posedge clk_sys);
        go <= 1'b1;
        @(posedge clk_sys);
        go   <= 1'b0;
        seen = 0;
        repeat (100)
        begin
            @(negedge clk_sys);
            if (shiftDropped === 1'b1)
                seen++;
        end
        cmp_bit(seen > 0, 1'b1);
        wait_busy(1'b0, PER + 100);
        expQ = {expQ[`SSR_STAGES-2:0], 1'b0};
        cmp_vec(stageQ, expQ);
        repeat (REST) @(posedge clk_sys);
    endtask

    task automatic t_preset;
        int n;
        @(posedge clk_sys);
        preset_two <= 19'h00220;
        preset_one <= 19'h00280;
        expQ[5] = 1'b0;
        expQ[7] = 1'b1;
        expQ[9] = 1'b0;
        n = 0;
        while (stageQ !== expQ && n < 20)
        begin
            @(negedge clk_sys);
            n++;
        end
        cmp_vec(stageQ, expQ);
        cmp_bit(shiftBusy, 1'b1);
        @(posedge clk_sys);
        preset_one <= 19'h00000;
        preset_two <= 19'h00000;
        wait_busy(1'b0, 50);
        cmp_vec(stageQ, expQ);
        shift_one(1'b1);
        cmp_vec(stageQ, expQ);
        cmp_vec(stageQn, ~expQ);
    endtask

    initial
    begin
        reset_n    = 1'b0;
        go         = 1'b0;
        fault      = 1'b0;
        preset_one = 19'h00000;
        preset_two = 19'h00000;
        miscompares = 0;
        cmp_count   = 0;
        t_reset();
        t_train();
        t_drop();
        t_preset();
        t_reset();
        complete_run();
    end
endmodule
